// [design/miip_pkg.sv]
/*
 * constants for the external media-independent port: field positions,
 * reset values and synchroniser figures.
 * assumes a single 40 MHz core clock; both phy clocks are sampled, not used as clocks.
 */
package miip_pkg;
	// ----------------------------------------
	// clocking and synchronisers
	// ----------------------------------------
	localparam int          CORE_CLK_HZ   = 40_000_000;
	localparam int          MDC_MAX_HZ    = 2_500_000;
	localparam int          MDC_MIN_HALF  = (CORE_CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
	localparam int          SYNC_STAGES   = 3;
	localparam int          SYNC_W        = 15;
	// ----------------------------------------
	// positions inside the synchronised vector
	// ----------------------------------------
	localparam int          SB_TXCLK      = 0;
	localparam int          SB_RXCLK      = 1;
	localparam int          SB_RXD        = 2;
	localparam int          SB_RXDV       = 6;
	localparam int          SB_RXER       = 7;
	localparam int          SB_CRS        = 8;
	localparam int          SB_COL        = 9;
	localparam int          SB_MDIO       = 10;
	localparam int          SB_LINK       = 11;
	localparam int          SB_DPX        = 12;
	localparam int          SB_SPD        = 13;
	localparam int          SB_SPARE      = 14;
	// ----------------------------------------
	// status byte layout and reset values
	// ----------------------------------------
	localparam int          ST_LINK_BIT   = 4;
	localparam int          ST_DPX_BIT    = 5;
	localparam int          ST_SPD_BIT    = 6;
	localparam logic [7:0]  STATUS_RST    = 8'h00;
	localparam logic [3:0]  NIB_RST       = 4'h0;
	localparam logic [14:0] SYNC_RST      = 15'h0000;
endpackage

// [design/miip_sync_if.sv]
/*
 * carrier between the pin synchroniser and the port logic.
 * assumes both ends run on core_clk.
 */
`timescale 1ns/1ps
interface miip_sync_if #(parameter int W = 15);
	logic [W-1:0] lvl;
	logic [W-1:0] lvl_d;
	modport src (output lvl, output lvl_d);
	modport dst (input lvl, input lvl_d);
endinterface

// [design/miip_pin_sync.sv]
/*
 * three-stage synchroniser with agreement filter for all pins from outside core_clk.
 * assumes pins may change at any time; a change counts once stages two and three agree.
 */
`timescale 1ns/1ps
module miip_pin_sync
	import miip_pkg::*;
#(
	parameter int W = SYNC_W
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	// raw pins
	input  wire logic [W-1:0] pins,
	// filtered levels
	miip_sync_if.src          so
);
	logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
	wire  [W-1:0] agree = ~(s2_r ^ s3_r);
	wire  [W-1:0] lvl_nxt = (agree & s3_r) | (~agree & lvl_r);

	// s1 feeds only s2; nothing else looks at it
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s1_r    <= W'(SYNC_RST);
			s2_r    <= W'(SYNC_RST);
			s3_r    <= W'(SYNC_RST);
			lvl_r   <= W'(SYNC_RST);
			lvl_d_r <= W'(SYNC_RST);
		end else if (ce) begin
			s1_r    <= pins;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			lvl_r   <= lvl_nxt;
			lvl_d_r <= lvl_r;
		end
	end

	assign so.lvl   = lvl_r;
	assign so.lvl_d = lvl_d_r;
endmodule

// [design/miip_port.sv]
/*
 * external media-independent port, mac side: nibble transmit and receive paths timed by
 * the phy clocks, carrier and collision status, software-driven management pins.
 * assumes the phy supplies both clocks (about 5 MHz in the 10 Mb case) and that software
 * paces the management clock through mgmt_clk_bit.
 */
`timescale 1ns/1ps
module miip_port
	import miip_pkg::*;
(
	// clock, reset, enable
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       ce,
	// pin sharing option
	input  wire logic       printer_port_option,
	// phy receive side pins
	input  wire logic       rx_clk_pin,
	input  wire logic [3:0] rxd_pin,
	input  wire logic       rx_dv_pin,
	input  wire logic       rx_er_pin,
	input  wire logic       crs_pin,
	input  wire logic       col_pin,
	// phy transmit side pins
	input  wire logic       tx_clk_pin,
	output logic            tx_en_pin,
	output logic [3:0]      txd_pin,
	// station management pins
	output logic            mdc_pin,
	input  wire logic       mdio_i,
	output logic            mdio_o,
	output logic            mdio_oe,
	// phy status pins
	input  wire logic       ext_phy_link_in,
	input  wire logic       ext_phy_duplex_in,
	input  wire logic       ext_phy_speed_in,
	// user transmit stream
	input  wire logic       tx_valid,
	input  wire logic [3:0] tx_data,
	output logic            tx_ack,
	// user receive stream
	output logic            rx_valid,
	output logic [3:0]      rx_data,
	output logic            rx_err,
	// management control bits
	input  wire logic       mgmt_clk_bit,
	input  wire logic       mgmt_out_bit,
	input  wire logic       mgmt_write,
	output logic            mgmt_in_bit,
	// status
	output logic            carrier,
	output logic            collision,
	output logic            tx_collision,
	output logic [7:0]      status_byte
);
	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	miip_sync_if #(.W(SYNC_W)) sy ();

	miip_pin_sync #(.W(SYNC_W)) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.ce       (ce),
		.pins     ({1'b0, ext_phy_speed_in, ext_phy_duplex_in, ext_phy_link_in, mdio_i, col_pin, crs_pin,
		            rx_er_pin, rx_dv_pin, rxd_pin, rx_clk_pin, tx_clk_pin}),
		.so       (sy.src)
	);

	// edge detectors stay blind until the pipeline holds real pin levels: the reset value
	// need not match a free-running phy clock and would otherwise fake a rise
	logic [2:0] fill_r;
	wire        primed   = (fill_r == 3'(SYNC_STAGES + 2));
	wire [2:0]  fill_nxt = primed ? fill_r : fill_r + 3'h1;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fill_r <= 3'h0;
		end else if (ce) begin
			fill_r <= fill_nxt;
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire       port_on   = ~printer_port_option;
	wire       tx_rise   = primed & sy.lvl[SB_TXCLK] & ~sy.lvl_d[SB_TXCLK];
	wire       rx_rise   = primed & sy.lvl[SB_RXCLK] & ~sy.lvl_d[SB_RXCLK];
	// lvl_d holds the data as it stood just before the clock edge, clear of the phy's own switching
	wire [3:0] rx_nib    = sy.lvl_d[SB_RXD +: 4];
	wire       rx_dv_s   = sy.lvl_d[SB_RXDV];
	wire       rx_take   = port_on & rx_rise & rx_dv_s;
	wire       tx_take   = port_on & tx_rise & tx_valid;
	wire       tx_en_nxt = port_on & tx_rise ? tx_valid : (tx_en_pin & port_on);
	wire [3:0] txd_nxt   = tx_take ? tx_data : (port_on ? txd_pin : NIB_RST);
	wire       col_s     = sy.lvl[SB_COL] & port_on;
	wire [7:0] status_nxt = port_on ? (8'(sy.lvl[SB_LINK]) << ST_LINK_BIT)
	                                | (8'(sy.lvl[SB_DPX]) << ST_DPX_BIT)
	                                | (8'(sy.lvl[SB_SPD]) << ST_SPD_BIT) : STATUS_RST;

	// ----------------------------------------
	// transmit path
	// ----------------------------------------
	// edges are seen a few core cycles late; fine while the phy clock is well under core_clk/6
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tx_en_pin    <= 1'b0;
			txd_pin      <= NIB_RST;
			tx_ack       <= 1'b0;
			tx_collision <= 1'b0;
		end else if (ce) begin
			tx_en_pin    <= tx_en_nxt;
			txd_pin      <= txd_nxt;
			tx_ack       <= tx_take;
			tx_collision <= col_s & tx_en_pin;
		end
	end

	// ----------------------------------------
	// receive path and status
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rx_valid    <= 1'b0;
			rx_data     <= NIB_RST;
			rx_err      <= 1'b0;
			carrier     <= 1'b0;
			collision   <= 1'b0;
			status_byte <= STATUS_RST;
		end else if (ce) begin
			rx_valid    <= rx_take;
			if (rx_take) begin
				rx_data <= rx_nib;
				rx_err  <= sy.lvl_d[SB_RXER];
			end
			carrier     <= sy.lvl[SB_CRS] & port_on;
			collision   <= col_s;
			status_byte <= status_nxt;
		end
	end

	// ----------------------------------------
	// station management
	// ----------------------------------------
	// bit-banged: software owns the pacing (2.5 MHz ceiling) and the frame format
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mdc_pin     <= 1'b0;
			mdio_o      <= 1'b0;
			mdio_oe     <= 1'b0;
			mgmt_in_bit <= 1'b0;
		end else if (ce) begin
			mdc_pin     <= mgmt_clk_bit & port_on;
			mdio_o      <= mgmt_out_bit;
			mdio_oe     <= mgmt_write & port_on;
			mgmt_in_bit <= sy.lvl[SB_MDIO];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_tx_edge_taken;
		ce && port_on && tx_rise && tx_valid;
	endsequence
	sequence s_rx_nibble;
		ce && port_on && rx_rise && rx_dv_s;
	endsequence

	chk_tx_en_edge: assert property (ce && $changed(tx_en_nxt) && port_on |-> tx_rise)
		else $error("tx enable moved without a tx clock edge");
	chk_tx_nibble: assert property (s_tx_edge_taken |=> tx_en_pin && txd_pin == $past(tx_data) && tx_ack)
		else $error("tx nibble not presented after edge");
	chk_tx_hold: assert property (ce && port_on && !tx_rise && tx_en_pin |=> tx_en_pin && $stable(txd_pin))
		else $error("tx output moved between edges");
	chk_rx_capture: assert property (s_rx_nibble |=> rx_valid && rx_data == $past(rx_nib))
		else $error("rx nibble not captured");
	chk_rx_quiet: assert property (ce && !(port_on && rx_rise && rx_dv_s) |=> !rx_valid)
		else $error("rx valid without dv at edge");
	chk_mdc_follow: assert property (ce && port_on |=> mdc_pin == $past(mgmt_clk_bit))
		else $error("mdc does not follow control bit");
	chk_mdio_release: assert property (ce && !mgmt_write |=> !mdio_oe)
		else $error("mdio driven while reading");
	chk_printer_quiet: assert property (ce && printer_port_option [*2] |=> !tx_en_pin && !mdio_oe && !rx_valid)
		else $error("port active with printer option");
	chk_status_bits: assert property (ce && port_on |=> status_byte[ST_DPX_BIT] == $past(sy.lvl[SB_DPX]))
		else $error("duplex status bit wrong");
	chk_crs_follow: assert property (ce && port_on |=> carrier == $past(sy.lvl[SB_CRS]))
		else $error("carrier status wrong");

	// every antecedent carries ce: a frozen cycle says nothing about the next one
	sequence s_port_off;
		ce && !port_on;
	endsequence
	sequence s_tx_drop;
		ce && port_on && tx_rise && !tx_valid;
	endsequence

	chk_tx_ack_pulse: assert property (ce && tx_ack |=> !tx_ack)
		else $error("tx ack longer than one cycle");
	chk_tx_stop: assert property (s_tx_drop |=> !tx_en_pin)
		else $error("tx enable held after valid dropped at an edge");
	chk_tx_col_gate: assert property (ce && !tx_en_pin |=> !tx_collision)
		else $error("tx collision flagged while idle");
	chk_tx_col_set: assert property (ce && port_on && tx_en_pin |=> tx_collision == $past(sy.lvl[SB_COL]))
		else $error("tx collision missed while sending");
	chk_col_follow: assert property (ce && port_on |=> collision == $past(sy.lvl[SB_COL]))
		else $error("collision status wrong");

	chk_rx_pulse: assert property (ce && rx_valid |=> !rx_valid)
		else $error("rx valid longer than one cycle");
	chk_rx_hold: assert property (ce && !rx_take |=> $stable(rx_data) && $stable(rx_err))
		else $error("rx data moved without a nibble");
	chk_rx_err_take: assert property (s_rx_nibble |=> rx_err == $past(sy.lvl_d[SB_RXER]))
		else $error("rx error flag not captured");

	chk_mdio_drive: assert property (ce && port_on && mgmt_write |=> mdio_oe && mdio_o == $past(mgmt_out_bit))
		else $error("mdio not driven from written bit");
	chk_mgmt_in: assert property (ce |=> mgmt_in_bit == $past(sy.lvl[SB_MDIO]))
		else $error("mdio input not readable");
	chk_status_link: assert property (ce && port_on |=> status_byte[ST_LINK_BIT] == $past(sy.lvl[SB_LINK]))
		else $error("link status bit wrong");
	chk_status_speed: assert property (ce && port_on |=> status_byte[ST_SPD_BIT] == $past(sy.lvl[SB_SPD]))
		else $error("speed status bit wrong");

	chk_off_tx: assert property (s_port_off |=> txd_pin == NIB_RST && !tx_ack)
		else $error("tx data active with printer option");
	chk_off_status: assert property (s_port_off |=> status_byte == STATUS_RST && !carrier && !collision)
		else $error("status active with printer option");
	chk_off_mdc: assert property (s_port_off |=> !mdc_pin)
		else $error("mdc active with printer option");
endmodule

// [verif/miip_phy_model.sv]
/* behavioural phy: free clocks, receive nibbles, transmit capture, status levels, mdio drive.
   assumes the bench resolves the mdio wire with its pull-up. */
`timescale 1ns/1ps
module miip_phy_model (
	// clocks and receive pins
	output logic            rx_clk,
	output logic            tx_clk,
	output logic [3:0]      rxd,
	output logic            rx_dv,
	output logic            rx_er,
	// status levels: speed duplex link col crs
	output logic [4:0]      sts,
	// transmit and management pins
	output logic            md_oe,
	output logic            md_o,
	input  wire logic       tx_en,
	input  wire logic [3:0] txd,
	input  wire logic       mdc,
	input  wire logic       mdio
);
	logic [3:0] tx_q [$];
	logic       md_seen;
	initial begin
		{rx_clk, tx_clk, rx_dv, rx_er, md_oe, md_o} = 6'h00;
		rxd = 4'h0;
		sts = 5'h00; // crs and col are set by the bench at any moment, free of both clocks
		fork
			#7 forever #100 rx_clk = ~rx_clk;
			#61 forever #100 tx_clk = ~tx_clk;
		join
	end
	always @(posedge tx_clk) if (tx_en === 1'b1) tx_q.push_back(txd);
	always @(posedge mdc) md_seen <= mdio;
	task automatic send_nib(input logic [3:0] d, input logic dv, input logic er);
		@(negedge rx_clk);
		// mid-period change keeps setup and hold round the rise; idle nibbles are inverted
		rxd = dv ? d : ~rxd;
		rx_dv = dv;
		rx_er = er;
	endtask
endmodule

// [verif/miip_port_tb.sv]
/* bench for miip_port: drives the user side, judges the pins through the phy model.
   assumes the phy model and a 40 MHz core clock; ce is high except during the freeze test. */
`timescale 1ns/1ps
module miip_port_tb;
	logic       core_clk, resetn, ce, prn, tx_valid, mclk, mout, mwr, rx_clk, tx_clk, rx_dv, rx_er;
	logic       tx_en_pin, mdc_pin, mdio_o, mdio_oe, md_oe, md_o, tx_ack, rx_valid, rx_err;
	logic       mgmt_in_bit, carrier, collision, tx_collision;
	logic [3:0] tx_data, rxd, txd_pin, rx_data;
	logic [4:0] sts;
	logic [7:0] status_byte;
	logic [4:0] rx_q [$];
	int         bad_count = 0;
	int         tests_run = 0;
	wire        mdio = mdio_oe ? mdio_o : (md_oe ? md_o : 1'b1); // pull-up when released
	miip_port u_dut (.core_clk(core_clk), .resetn(resetn), .ce(ce), .printer_port_option(prn),
		.rx_clk_pin(rx_clk), .rxd_pin(rxd), .rx_dv_pin(rx_dv), .rx_er_pin(rx_er), .crs_pin(sts[0]),
		.col_pin(sts[1]), .tx_clk_pin(tx_clk), .tx_en_pin(tx_en_pin), .txd_pin(txd_pin), .mdc_pin(mdc_pin),
		.mdio_i(mdio), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .ext_phy_link_in(sts[2]),
		.ext_phy_duplex_in(sts[3]), .ext_phy_speed_in(sts[4]), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ack(tx_ack), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .mgmt_clk_bit(mclk),
		.mgmt_out_bit(mout), .mgmt_write(mwr), .mgmt_in_bit(mgmt_in_bit), .carrier(carrier),
		.collision(collision), .tx_collision(tx_collision), .status_byte(status_byte));
	miip_phy_model u_phy (.rx_clk(rx_clk), .tx_clk(tx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
		.sts(sts), .md_oe(md_oe), .md_o(md_o), .tx_en(tx_en_pin), .txd(txd_pin), .mdc(mdc_pin), .mdio(mdio));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (rx_valid === 1'b1) rx_q.push_back({rx_err, rx_data});
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic tx_send(input logic [3:0] d);
		tx_valid <= 1'b1;
		tx_data <= d;
		repeat (40) begin
			@(posedge core_clk);
			if (tx_ack === 1'b1) break;
		end
		chk("tx_ack", 8'(tx_ack), 8'h01);
	endtask
	task automatic t_tx();
		logic [3:0] exp_n [3] = '{4'h5, 4'hA, 4'hF};
		u_phy.sts[1] <= 1'b1;
		cyc(8);
		chk("tx_col", 8'(tx_collision), 8'h00);
		foreach (exp_n[i]) tx_send(exp_n[i]);
		chk("tx_en", 8'(tx_en_pin), 8'h01);
		chk("tx_col", 8'(tx_collision), 8'h01);
		chk("col", 8'(collision), 8'h01);
		tx_valid <= 1'b0;
		u_phy.sts[1] <= 1'b0;
		cyc(24);
		chk("col", 8'(collision), 8'h00);
		chk("tx_en", 8'(tx_en_pin), 8'h00);
		chk("tx_cnt", 8'(u_phy.tx_q.size()), 8'h03);
		foreach (exp_n[i]) chk("txd", 8'(u_phy.tx_q[i]), 8'(exp_n[i]));
	endtask
	task automatic t_rx();
		logic [4:0] exp_r [3] = '{5'h0A, 5'h03, 5'h1C};
		u_phy.sts[0] <= 1'b1;
		u_phy.send_nib(4'h9, 1'b0, 1'b0);
		foreach (exp_r[i]) u_phy.send_nib(exp_r[i][3:0], 1'b1, exp_r[i][4]);
		u_phy.send_nib(4'h0, 1'b0, 1'b0);
		chk("carrier", 8'(carrier), 8'h01);
		u_phy.sts[0] <= 1'b0;
		u_phy.send_nib(4'h0, 1'b0, 1'b0);
		cyc(8);
		chk("carrier", 8'(carrier), 8'h00);
		chk("rx_cnt", 8'(rx_q.size()), 8'h03);
		foreach (exp_r[i]) chk("rx", 8'(rx_q[i]), 8'(exp_r[i]));
	endtask
	task automatic t_status();
		for (int i = 0; i < 8; i++) begin
			u_phy.sts[4:2] <= 3'(i);
			cyc(8);
			chk("status", status_byte, {1'b0, 3'(i), 4'h0});
		end
	endtask
	task automatic t_mgmt();
		mwr <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			mclk <= 1'b0;
			mout <= i[0];
			cyc(8); // 200 ns halves hold mdc at 2.5 MHz
			chk("mdc", 8'(mdc_pin), 8'h00);
			chk("mdio_oe", 8'(mdio_oe), 8'h01);
			mclk <= 1'b1;
			cyc(2);
			chk("mdc", 8'(mdc_pin), 8'h01);
			chk("md_seen", 8'(u_phy.md_seen), 8'(i[0]));
			cyc(6);
		end
		mwr <= 1'b0;
		u_phy.md_oe <= 1'b1;
		u_phy.md_o <= 1'b0;
		cyc(8);
		chk("mdio_oe", 8'(mdio_oe), 8'h00);
		chk("mgmt_in", 8'(mgmt_in_bit), 8'h00);
		u_phy.md_oe <= 1'b0;
		cyc(8);
		chk("mgmt_in", 8'(mgmt_in_bit), 8'h01);
	endtask
	task automatic t_freeze();
		ce <= 1'b0;
		mclk <= 1'b0;
		cyc(4);
		chk("mdc_frz", 8'(mdc_pin), 8'h01);
		ce <= 1'b1;
		cyc(2);
		chk("mdc", 8'(mdc_pin), 8'h00);
	endtask
	task automatic t_printer();
		prn <= 1'b1;
		mwr <= 1'b1;
		mclk <= 1'b1;
		tx_valid <= 1'b1;
		u_phy.sts[4:2] <= 3'h7;
		rx_q.delete();
		u_phy.send_nib(4'h5, 1'b1, 1'b0);
		u_phy.send_nib(4'h5, 1'b0, 1'b0);
		cyc(8);
		chk("tx_en", 8'(tx_en_pin), 8'h00);
		chk("mdc", 8'(mdc_pin), 8'h00);
		chk("mdio_oe", 8'(mdio_oe), 8'h00);
		chk("status", status_byte, 8'h00);
		chk("rx_cnt", 8'(rx_q.size()), 8'h00);
		chk("tx_cnt", 8'(u_phy.tx_q.size()), 8'h03);
	endtask
	initial begin
		{resetn, prn, tx_valid, mclk, mout, mwr} = 6'h00;
		ce = 1'b1;
		tx_data = 4'h0;
		cyc(10);
		resetn <= 1'b1;
		cyc(8);
		chk("tx_en", 8'(tx_en_pin), 8'h00);
		t_tx();
		t_rx();
		t_status();
		t_mgmt();
		t_freeze();
		t_printer();
		end_of_test();
	end
	initial begin
		#100000;
		bad_count++;
		end_of_test();
	end
endmodule
